/* rtl/sar_adc_pkg.sv */
// Package: register map, field layout and timing constants of the converter
package sar_adc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_PORTREF = 12'h004;
  localparam logic [11:0] OFF_TIMING = 12'h008;
  localparam logic [11:0] OFF_RESULT_HIGH = 12'h00c;
  localparam logic [11:0] OFF_RESULT_LOW = 12'h010;
  localparam logic [11:0] OFF_FLAGS = 12'h014;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_ENABLE = 0;
  localparam int CTL_START = 1;
  localparam int CTL_CHAN_LSB = 2;
  localparam int PR_NEG_REF = 5;
  localparam int PR_POS_REF = 4;
  localparam int TF_JUSTIFY = 7;
  localparam int TF_ACQ_LSB = 3;
  localparam int TF_CLK_LSB = 0;
  localparam int FL_DONE = 0;
  localparam int FL_IRQ_EN = 1;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [3:0] PCFG_FUSE_SET = 4'h0;
  localparam logic [3:0] PCFG_FUSE_CLEAR = 4'h7;
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  localparam logic [3:0] CHAN_LAST = 4'hc;
  localparam logic [4:0] CONV_PERIODS = 5'h0b;
  localparam logic [4:0] GAP_PERIODS = 5'h02;
  localparam int PINS = 13;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic negRef;
    logic posRef;
    logic [12:0] analogPins;
    logic [3:0] channel;
    logic channelValid;
  } analog_ctl_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_ACQUIRE, ST_RC_DELAY, ST_CONVERT, ST_GAP
  } conv_state_t;

endpackage

/* rtl/sar_adc_sequencer.sv */
// Sequencer and APB register file of a 10-bit successive-approximation ADC
// Function
// - Bit 5 selects negative reference: pin two when 1, ground when 0.
// - Bit 4 selects positive reference: pin three when 1, supply when 0.
// - Pin code 0-2 all analog; each higher code makes one more digital.
// - Pin config resets to 0000 if fuse is 1, else 0111.
// - Acquisition codes 7..0 give 20,16,12,8,6,4,2,0 bit periods.
// - Clock codes give clk/2,8,32,4,16,64; x11 selects internal RC clock.
// - RC clock start delayed by one instruction cycle.
// - Completion loads result pair, clears start bit, sets done flag.
// - Reset returns registers, turns converter off, aborts conversion.
// - Result pair is not initialised by reset.
// - Nonzero acquisition code: sample programmed periods then convert.
// - Acquisition code 000 converts at once; it is the reset value.
// - After conversion resume sampling; no acquisition-end indication.
// - Conversion takes eleven bit periods.
// - At least two bit periods between conversion and next acquisition.
// - Holding capacitor disconnected once conversion begins.
// - Channel codes 0-12 route channels; higher codes unimplemented.
// - Start bit reads 1 while converting; enable bit switches module.
// - Clearing start aborts conversion; result keeps previous value.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int INSTR_CYCLE = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic portbAnalogFuse,
  input wire logic rcClockTick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compareHigh,
  output logic [9:0] trialCode,
  output logic sampleConnect,
  output logic convDoneIrq,
  output analog_ctl_t analogCtl
);

  if (INSTR_CYCLE < 1 || INSTR_CYCLE > 255) begin : g_bad_cycle
    $error("INSTR_CYCLE out of range");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic enable_q, start_q, justify_q, done_q, irqEn_q, fuseSeen_q;
  logic negRef_q, posRef_q;
  logic [3:0] chan_q, pcfg_q;
  logic [2:0] acq_q, clkSel_q;
  logic [7:0] resHigh_q, resLow_q;
  logic [9:0] sar_q;
  logic [5:0] div_q;
  logic [4:0] tad_q;
  logic [7:0] dly_q;
  conv_state_t state_q, state_d;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h7: acq_periods = 5'h14;
      3'h6: acq_periods = 5'h10;
      3'h5: acq_periods = 5'h0c;
      3'h4: acq_periods = 5'h08;
      3'h3: acq_periods = 5'h06;
      3'h2: acq_periods = 5'h04;
      3'h1: acq_periods = 5'h02;
      3'h0: acq_periods = 5'h00;
    endcase
  endfunction

  function automatic logic [5:0] div_mask(input logic [2:0] code);
    unique case (code)
      3'h0: div_mask = 6'h01;
      3'h1: div_mask = 6'h07;
      3'h2: div_mask = 6'h1f;
      3'h4: div_mask = 6'h03;
      3'h5: div_mask = 6'h0f;
      3'h6: div_mask = 6'h3f;
      default: div_mask = 6'h00;
    endcase
  endfunction

  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic wrAcc = access && pwrite;
  wire logic wrCtl = wrAcc && paddr == OFF_CONTROL;
  wire logic wrPr = wrAcc && paddr == OFF_PORTREF;
  wire logic wrTf = wrAcc && paddr == OFF_TIMING;
  wire logic wrRh = wrAcc && paddr == OFF_RESULT_HIGH;
  wire logic wrRl = wrAcc && paddr == OFF_RESULT_LOW;
  wire logic wrFl = wrAcc && paddr == OFF_FLAGS;
  wire logic mapped = paddr == OFF_CONTROL || paddr == OFF_PORTREF ||
      paddr == OFF_TIMING || paddr == OFF_RESULT_HIGH ||
      paddr == OFF_RESULT_LOW || paddr == OFF_FLAGS;
  wire logic useRc = clkSel_q[1:0] == 2'h3;
  wire logic [5:0] mask = div_mask(clkSel_q);
  // One bit-period tick, from the divider or the RC oscillator
  wire logic tadTick = useRc ? rcClockTick : (div_q == mask);
  wire logic busy = state_q == ST_ACQUIRE || state_q == ST_RC_DELAY ||
      state_q == ST_CONVERT;
  // Start taken only while sampling, so it cannot stick during the gap
  wire logic goReq = wrCtl && pwdata[CTL_START] && pwdata[CTL_ENABLE] &&
      enable_q && state_q == ST_SAMPLE;
  // Clearing start or the enable aborts a conversion in flight
  wire logic abort = wrCtl && busy &&
      (!pwdata[CTL_START] || !pwdata[CTL_ENABLE]);
  wire logic lastBit = state_q == ST_CONVERT && tadTick &&
      tad_q == CONV_PERIODS - 5'h01;
  wire logic complete = lastBit && !abort;
  wire logic [9:0] finalCode = sar_q | {9'h000, compareHigh};
  // Right-justified in low ten bits, left-justified in upper ten
  wire logic [15:0] resultWord = justify_q ? {6'h00, finalCode} :
      {finalCode, 6'h00};
  wire logic [4:0] acqLen = acq_periods(acq_q);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: if (enable_q) state_d = ST_SAMPLE;
      ST_SAMPLE: begin
        if (goReq) begin
          if (useRc) state_d = ST_RC_DELAY;
          else if (acq_q == ACQ_MANUAL) state_d = ST_CONVERT;
          else state_d = ST_ACQUIRE;
        end
      end
      ST_RC_DELAY: begin
        if (dly_q == 8'h00) begin
          state_d = (acq_q == ACQ_MANUAL) ? ST_CONVERT : ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (tadTick && tad_q == acqLen - 5'h01) state_d = ST_CONVERT;
      end
      ST_CONVERT: if (lastBit) state_d = ST_GAP;
      ST_GAP: begin
        if (tadTick && tad_q == GAP_PERIODS - 5'h01) begin
          state_d = ST_SAMPLE;
        end
      end
    endcase
    if (abort) state_d = ST_GAP;
    if (!enable_q) state_d = ST_OFF;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OFF;
      tad_q <= 5'h00;
      div_q <= 6'h00;
      dly_q <= 8'h00;
      sar_q <= 10'h000;
    end else begin
      state_q <= state_d;
      div_q <= (tadTick || useRc || state_q == ST_SAMPLE) ? 6'h00 :
          div_q + 6'h01;
      if (state_d != state_q) tad_q <= 5'h00;
      else if (tadTick) tad_q <= tad_q + 5'h01;
      if (goReq) dly_q <= 8'(INSTR_CYCLE - 1);
      else if (dly_q != 8'h00) dly_q <= dly_q - 8'h01;
      // Successive approximation, most significant bit first
      if (state_q != ST_CONVERT) sar_q <= 10'h200;
      else if (tadTick && tad_q < 5'h0a) begin
        sar_q <= (sar_q & ~(10'h200 >> tad_q[3:0])) |
            ({9'h000, compareHigh} << (4'h9 - tad_q[3:0])) |
            (10'h100 >> tad_q[3:0]);
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= 1'b0;
      start_q <= 1'b0;
      chan_q <= 4'h0;
      negRef_q <= 1'b0;
      posRef_q <= 1'b0;
      pcfg_q <= PCFG_FUSE_SET;
      fuseSeen_q <= 1'b0;
      justify_q <= 1'b0;
      acq_q <= ACQ_MANUAL;
      clkSel_q <= 3'h0;
      done_q <= 1'b0;
      irqEn_q <= 1'b0;
    end else begin
      fuseSeen_q <= 1'b1;
      if (!fuseSeen_q) begin
        pcfg_q <= portbAnalogFuse ? PCFG_FUSE_SET : PCFG_FUSE_CLEAR;
      end else if (wrPr) begin
        pcfg_q <= pwdata[3:0];
      end
      if (wrCtl) begin
        enable_q <= pwdata[CTL_ENABLE];
        chan_q <= pwdata[CTL_CHAN_LSB +: 4];
      end
      if (goReq) start_q <= 1'b1;
      else if (complete || abort || (wrCtl && !pwdata[CTL_ENABLE])) begin
        start_q <= 1'b0;
      end
      if (wrPr) begin
        negRef_q <= pwdata[PR_NEG_REF];
        posRef_q <= pwdata[PR_POS_REF];
      end
      if (wrTf) begin
        justify_q <= pwdata[TF_JUSTIFY];
        acq_q <= pwdata[TF_ACQ_LSB +: 3];
        clkSel_q <= pwdata[TF_CLK_LSB +: 3];
      end
      if (wrFl) irqEn_q <= pwdata[FL_IRQ_EN];
      // Completion wins over a software clear in the same cycle
      if (complete) done_q <= 1'b1;
      else if (wrFl && !pwdata[FL_DONE]) done_q <= 1'b0;
    end
  end

  // Result pair has no reset
  always_ff @(posedge clk) begin
    if (complete) begin
      resHigh_q <= resultWord[15:8];
      resLow_q <= resultWord[7:0];
    end else begin
      if (wrRh) resHigh_q <= pwdata[7:0];
      if (wrRl) resLow_q <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire logic [31:0] rdMux =
      paddr == OFF_CONTROL ? {26'h0, chan_q, start_q && enable_q, enable_q} :
      paddr == OFF_PORTREF ? {26'h0, negRef_q, posRef_q, pcfg_q} :
      paddr == OFF_TIMING ? {24'h0, justify_q, 1'b0, acq_q, clkSel_q} :
      paddr == OFF_RESULT_HIGH ? {24'h0, resHigh_q} :
      paddr == OFF_RESULT_LOW ? {24'h0, resLow_q} :
      paddr == OFF_FLAGS ? {30'h0, irqEn_q, done_q} : 32'h0;
  // Pins above the code count turn digital from the top pin down
  function automatic logic [12:0] analog_map(input logic [3:0] code);
    analog_map = (code <= 4'h2) ? 13'h1fff :
        13'h1fff >> (code - 4'h2);
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      trialCode <= 10'h000;
      sampleConnect <= 1'b0;
      convDoneIrq <= 1'b0;
      analogCtl <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup && !pwrite ? rdMux : 32'h0;
      trialCode <= sar_q;
      sampleConnect <= state_d == ST_SAMPLE ||
          state_d == ST_ACQUIRE || state_d == ST_RC_DELAY;
      convDoneIrq <= done_q && irqEn_q;
      analogCtl.negRef <= negRef_q;
      analogCtl.posRef <= posRef_q;
      analogCtl.analogPins <= analog_map(pcfg_q);
      analogCtl.channel <= chan_q;
      analogCtl.channelValid <= chan_q <= CHAN_LAST;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_conv_length: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_q == ST_CONVERT) |-> state_q == ST_CONVERT [*8])
    else $error("conversion ended early");
  a_done_sets: assert property (@(posedge clk) disable iff (!reset_n)
    complete |=> done_q && !start_q)
    else $error("done not signalled");
  a_manual_go: assert property (@(posedge clk) disable iff (!reset_n)
    goReq && !useRc && acq_q == ACQ_MANUAL |=> state_q == ST_CONVERT)
    else $error("manual start not immediate");
  a_auto_acq: assert property (@(posedge clk) disable iff (!reset_n)
    goReq && !useRc && acq_q != ACQ_MANUAL |=> state_q == ST_ACQUIRE)
    else $error("acquisition skipped");
  a_rc_delay: assert property (@(posedge clk) disable iff (!reset_n)
    goReq && useRc |=> state_q == ST_RC_DELAY)
    else $error("rc delay missing");
  a_gap_after: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_CONVERT && state_d != ST_CONVERT && enable_q
    |=> state_q == ST_GAP)
    else $error("no gap after conversion");
  a_abort_keep: assert property (@(posedge clk) disable iff (!reset_n)
    abort && !complete |=> $stable(resHigh_q) && $stable(resLow_q))
    else $error("result changed on abort");
  a_hold_open: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == ST_CONVERT |=> !sampleConnect)
    else $error("capacitor connected in conversion");
  a_off_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !enable_q |=> state_q == ST_OFF)
    else $error("module runs while off");

  c_manual: cover property (@(posedge clk) disable iff (!reset_n)
    goReq && acq_q == ACQ_MANUAL);
  c_auto: cover property (@(posedge clk) disable iff (!reset_n)
    complete && acq_q != ACQ_MANUAL);
  c_abort: cover property (@(posedge clk) disable iff (!reset_n) abort);

endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking testbench of the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sar_adc_pkg::*;
  logic clk = 0, reset_n = 0, portbAnalogFuse = 0, rcClockTick = 0;
  logic psel = 0, penable = 0, pwrite = 0, compareHigh = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sampleConnect, convDoneIrq;
  logic [9:0] trialCode;
  analog_ctl_t analogCtl;
  int fail_count = 0, comparisons = 0, tickCnt = 0;

  sar_adc_sequencer #(.INSTR_CYCLE(1)) dut (.clk(clk), .reset_n(reset_n),
    .portbAnalogFuse(portbAnalogFuse), .rcClockTick(rcClockTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compareHigh(compareHigh), .trialCode(trialCode),
    .sampleConnect(sampleConnect), .convDoneIrq(convDoneIrq),
    .analogCtl(analogCtl));

  always #20 clk = ~clk;

  // RC bit period of five system clocks
  always @(posedge clk) begin
    tickCnt <= (tickCnt == 4) ? 0 : tickCnt + 1;
    rcClockTick <= (tickCnt == 4);
  end

  // ****************************************************************
  // Bus and checking helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkr(input int v, input int lo, input int hi);
    comparisons++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, v, lo);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, '0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic do_reset(input logic fuse);
    @(posedge clk);
    reset_n <= 0;
    portbAnalogFuse <= fuse;
    repeat (8) @(posedge clk);
    reset_n <= 1;
    repeat (2) @(posedge clk);
  endtask

  // Enables, starts and measures acquisition, conversion and gap lengths
  task automatic conv(input logic [7:0] tf, output int acq, output int cv,
                      output int gap);
    wr(OFF_FLAGS, 32'h2);
    wr(OFF_TIMING, {24'h0, tf});
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_CONTROL, 32'h3);
    acq = 0;
    cv = 0;
    // The flag output lags completion by one register stage
    gap = 1;
    while (sampleConnect !== 1'b0 && acq < 3000) begin
      @(posedge clk);
      acq++;
    end
    while (convDoneIrq !== 1'b1 && cv < 3000) begin
      @(posedge clk);
      cv++;
    end
    while (sampleConnect !== 1'b1 && gap < 3000) begin
      @(posedge clk);
      gap++;
    end
    if (acq >= 3000 || cv >= 3000 || gap >= 3000) fail_count++;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values;
    logic [31:0] r;
    logic e;
    rd(OFF_PORTREF, 32'h07);
    rd(OFF_TIMING, 32'h00);
    chk({19'h0, analogCtl.analogPins}, 32'h00ff);
    apb(1'b0, 12'h020, '0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  task automatic t_pins;
    logic [12:0] exp;
    for (int c = 0; c < 16; c++) begin
      wr(OFF_PORTREF, {26'h0, c[1], c[0], c[3:0]});
      exp = (c <= 2) ? 13'h1fff : 13'h1fff >> (c - 2);
      repeat (2) @(posedge clk);
      chk({19'h0, analogCtl.analogPins}, {19'h0, exp});
      chk({31'h0, analogCtl.negRef}, {31'h0, c[1]});
      chk({31'h0, analogCtl.posRef}, {31'h0, c[0]});
    end
  endtask

  task automatic t_channel;
    wr(OFF_CONTROL, 32'h31);
    repeat (2) @(posedge clk);
    chk({28'h0, analogCtl.channel}, 32'hc);
    chk({31'h0, analogCtl.channelValid}, 32'h1);
    wr(OFF_CONTROL, 32'h35);
    repeat (2) @(posedge clk);
    chk({31'h0, analogCtl.channelValid}, 32'h0);
    wr(OFF_CONTROL, 32'h0);
  endtask

  task automatic t_justify;
    int a, c, g;
    compareHigh <= 1;
    conv(8'h80, a, c, g);
    rd(OFF_RESULT_HIGH, 32'h03);
    rd(OFF_RESULT_LOW, 32'hff);
    rd(OFF_CONTROL, 32'h1);
    rd(OFF_FLAGS, 32'h3);
    chkr(g, 4, 8);
    chk({22'h0, trialCode}, 32'h200);
    conv(8'h00, a, c, g);
    rd(OFF_RESULT_HIGH, 32'hff);
    rd(OFF_RESULT_LOW, 32'hc0);
  endtask

  task automatic t_acq;
    int p[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int a, c, g;
    for (int k = 1; k < 8; k++) begin
      conv({2'b10, k[2:0], 3'b000}, a, c, g);
      chkr(a, 2 * p[k], 2 * p[k] + 4);
      chkr(g, 4, 8);
    end
  endtask

  task automatic t_clocks;
    int code[8] = '{0, 1, 2, 4, 5, 6, 3, 7};
    int dv[8] = '{2, 8, 32, 4, 16, 64, 5, 5};
    int a, c, g;
    for (int k = 0; k < 8; k++) begin
      conv({5'b10000, code[k][2:0]}, a, c, g);
      chkr(a + c, 10 * dv[k], 13 * dv[k] + 8);
    end
  endtask

  task automatic t_abort;
    int a, c, g;
    compareHigh <= 1;
    conv(8'h80, a, c, g);
    compareHigh <= 0;
    wr(OFF_FLAGS, 32'h2);
    wr(OFF_TIMING, 32'h86);
    wr(OFF_CONTROL, 32'h3);
    repeat (40) @(posedge clk);
    rd(OFF_CONTROL, 32'h3);
    wr(OFF_CONTROL, 32'h1);
    repeat (900) @(posedge clk);
    rd(OFF_RESULT_LOW, 32'hff);
    rd(OFF_RESULT_HIGH, 32'h03);
    rd(OFF_FLAGS, 32'h2);
  endtask

  task automatic t_midreset;
    wr(OFF_TIMING, 32'h86);
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_CONTROL, 32'h3);
    repeat (30) @(posedge clk);
    do_reset(1'b1);
    rd(OFF_CONTROL, 32'h0);
    rd(OFF_PORTREF, 32'h0);
    rd(OFF_TIMING, 32'h0);
    rd(OFF_FLAGS, 32'h0);
    chk({31'h0, convDoneIrq}, 32'h0);
  endtask

  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    stop_test();
  end

  initial begin
    do_reset(1'b0);
    t_reset_values();
    t_pins();
    t_channel();
    t_justify();
    t_acq();
    t_clocks();
    t_abort();
    t_midreset();
    stop_test();
  end
endmodule
`default_nettype wire
